/* File: cec_retry_rx.sv */
// transmit retry accounting and receive acceptance with three aged frame buffers
// assumes the bit engine reports tx events and rx header destinations as
// one-cycle pulses on this clock; registers are reached over avalon-mm
// Functional notes
// R1: set exhausted flag when retries fail
// R2: exhausted flag sticks until software clear
// R3: flag meaningful only when mask enabled
// R4: three-bit retry limit, resets to one
// R5: software keeps retry limit at most five
// R6: four-bit no-acknowledge count, reset zero
// R7: four-bit low-drive count, upper nibble
// R8: tx start clears both error counters
// R9: receiver watches bus once powered up
// R10: reception completion raises receive event
// R11: refuse-ack bit suppresses all acknowledges
// R12: three logical addresses reset to 1111
// R13: mask bits 6:4 enable address matches
// R14: full enabled buffers refuse new messages
// R15: buffer-mode bit enables all three buffers
// R16: two-bit age per buffer, 00 empty
// R17: ages of buffers 0,1 at 1:0,3:2
// R18: tx start auto-clears at transmission end
// R19: exactly one outcome flagged per message
// R20: store in lowest free buffer, stamp age
// R21: each error consumes one retry attempt
// R22: release renumbers ages oldest to 01
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module cec_retry_rx (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  output logic      [1:0]   avs_response,
  input  wire logic         tx_noack_event,
  input  wire logic         low_drive_error,
  input  wire logic         tx_done_ok,
  input  wire logic         tx_arb_lost,
  input  wire logic         rx_frame_end,
  input  wire logic [3:0]   rx_dest_addr,
  input  wire logic         rx_is_polling,
  output logic              tx_go,
  output logic              tx_retransmit,
  output logic              module_power_on,
  output logic              rx_ack_enable,
  output logic              rx_store,
  output logic      [1:0]   rx_store_index,
  output logic              rx_event
);
  logic [2:0] tx_retry_limit_q;
  logic [3:0] tx_noack_count_q, tx_low_drive_count_q;
  logic       rx_refuse_ack_q, rx_multi_buffer_enable_q;
  logic [2:0] rx_address_enable_mask_q;
  logic [3:0] laddr_q [3];
  logic [2:0] tx_status_q;
  logic [2:0] attempts_q;
  logic [1:0] age_q [3];
  logic       waited_q;
  logic       wr_acc, rd_acc;
  logic [7:0] idx;
  logic       tx_error, tx_retry_exhausted_live, tx_end;
  logic       addr_hit, store_ok, release_ok;
  logic [1:0] free_idx, nbuf_used;
  logic       free_any;
  logic [1:0] rel_idx;
  logic [1:0] rel_age;
  logic [31:0] rdata;
  logic        mapped;

  // one wait cycle keeps read data registered and gives a fixed two-cycle answer
  assign idx    = avs_address;
  assign wr_acc = avs_write && waited_q;
  assign rd_acc = avs_read && waited_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waited_q <= 1'b0;
    end else begin
      waited_q <= (avs_read || avs_write) && !waited_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !waited_q);
    end
  end

  // control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_retry_limit_q         <= cec_retry_rx_pkg::RETRY_RST;
      rx_refuse_ack_q          <= 1'b0;
      rx_address_enable_mask_q <= cec_retry_rx_pkg::MASK_RST;
      laddr_q[0]               <= cec_retry_rx_pkg::LADDR_RST;
      laddr_q[1]               <= cec_retry_rx_pkg::LADDR_RST;
      laddr_q[2]               <= cec_retry_rx_pkg::LADDR_RST;
      rx_multi_buffer_enable_q <= 1'b0;
      module_power_on          <= 1'b0;
    end else if (wr_acc && avs_byteenable[0]) begin
      unique case (idx)
        // R4: retry limit field
        cec_retry_rx_pkg::IDX_RETRY:
          tx_retry_limit_q <= avs_writedata[cec_retry_rx_pkg::RETRY_LSB +: 3];
        cec_retry_rx_pkg::IDX_RXCTRL: begin
          rx_refuse_ack_q          <= avs_writedata[cec_retry_rx_pkg::REFUSE_BIT];
          rx_address_enable_mask_q <= avs_writedata[cec_retry_rx_pkg::MASK_LSB +: 3];
        end
        cec_retry_rx_pkg::IDX_LADDR01: begin
          laddr_q[0] <= avs_writedata[3:0];
          laddr_q[1] <= avs_writedata[cec_retry_rx_pkg::LADDR1_LSB +: 4];
        end
        cec_retry_rx_pkg::IDX_LADDR2:  laddr_q[2] <= avs_writedata[3:0];
        cec_retry_rx_pkg::IDX_POWER:   module_power_on <= avs_writedata[0];
        cec_retry_rx_pkg::IDX_BUFMODE: rx_multi_buffer_enable_q <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  // transmit side
  assign tx_error = tx_go && (tx_noack_event || low_drive_error);
  // R21: error past the allowed attempts
  assign tx_retry_exhausted_live = tx_error && (attempts_q >= tx_retry_limit_q);
  assign tx_end = tx_go && (tx_done_ok || tx_arb_lost || tx_retry_exhausted_live);

  // R18: start by write, clear at end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_go <= 1'b0;
    end else if (wr_acc && idx == cec_retry_rx_pkg::IDX_TXGO && avs_byteenable[0]) begin
      tx_go <= avs_writedata[0];
    end else if (tx_end) begin
      tx_go <= 1'b0;
    end
  end

  // R21: one attempt per error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      attempts_q    <= 3'h0;
      tx_retransmit <= 1'b0;
    end else begin
      tx_retransmit <= tx_error && !tx_retry_exhausted_live;
      if (wr_acc && idx == cec_retry_rx_pkg::IDX_TXGO && avs_writedata[0]) begin
        attempts_q <= 3'h0;
      end else if (tx_error && !tx_retry_exhausted_live) begin
        attempts_q <= attempts_q + 3'h1;
      end
    end
  end

  // R6: no-ack counter
  // R7: low-drive counter
  // R8: cleared by tx start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_noack_count_q     <= 4'h0;
      tx_low_drive_count_q <= 4'h0;
    end else if (wr_acc && idx == cec_retry_rx_pkg::IDX_TXGO && avs_writedata[0]) begin
      tx_noack_count_q     <= 4'h0;
      tx_low_drive_count_q <= 4'h0;
    end else begin
      if (tx_go && tx_noack_event) begin
        tx_noack_count_q <= tx_noack_count_q + 4'h1;
      end
      if (tx_go && low_drive_error) begin
        tx_low_drive_count_q <= tx_low_drive_count_q + 4'h1;
      end
    end
  end

  // R1: sticky outcome flags; set wins over clear
  // R2: held until clear write
  // R3: mask gating lives in the interrupt block outside
  // R19: priority keeps outcomes exclusive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_status_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_acc && idx == cec_retry_rx_pkg::IDX_CLEAR && avs_writedata[i]) begin
          tx_status_q[i] <= 1'b0;
        end
      end
      if (tx_go && tx_done_ok) begin
        tx_status_q[cec_retry_rx_pkg::SENT_BIT] <= 1'b1;
      end else if (tx_go && tx_arb_lost) begin
        tx_status_q[cec_retry_rx_pkg::ARB_BIT] <= 1'b1;
      end else if (tx_retry_exhausted_live) begin
        tx_status_q[cec_retry_rx_pkg::RETRY_EXH_BIT] <= 1'b1;
      end
    end
  end

  // receive side
  // R12: enable-masked addresses
  // R13: destination must match an enabled one
  always_comb begin
    addr_hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (rx_address_enable_mask_q[i] && laddr_q[i] == rx_dest_addr) begin
        addr_hit = 1'b1;
      end
    end
  end

  // R15: mode bit clear limits to buffer 0
  // R20: lowest free buffer first
  always_comb begin
    free_any  = 1'b0;
    free_idx  = 2'h0;
    nbuf_used = 2'h0;
    for (int i = cec_retry_rx_pkg::NBUF - 1; i >= 0; i--) begin
      if ((i == 0 || rx_multi_buffer_enable_q) && age_q[i] == cec_retry_rx_pkg::AGE_EMPTY) begin
        free_any = 1'b1;
        free_idx = 2'(i);
      end
      if (age_q[i] != cec_retry_rx_pkg::AGE_EMPTY) begin
        nbuf_used = nbuf_used + 2'h1;
      end
    end
  end

  // R9: only while powered
  // R14: full buffers refuse
  assign store_ok = module_power_on && rx_frame_end && addr_hit && !rx_is_polling
                    && free_any && !rx_refuse_ack_q;
  assign rel_idx    = avs_writedata[1:0];
  assign release_ok = wr_acc && idx == cec_retry_rx_pkg::IDX_RXRELEASE
                      && rel_idx < 2'(cec_retry_rx_pkg::NBUF);
  assign rel_age    = release_ok ? age_q[rel_idx] : cec_retry_rx_pkg::AGE_EMPTY;

  // R16: ages per buffer
  // R22: renumber on release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cec_retry_rx_pkg::NBUF; i++) begin
        age_q[i] <= cec_retry_rx_pkg::AGE_EMPTY;
      end
    end else begin
      for (int i = 0; i < cec_retry_rx_pkg::NBUF; i++) begin
        if (release_ok && rel_idx == 2'(i)) begin
          age_q[i] <= cec_retry_rx_pkg::AGE_EMPTY;
        end else if (rel_age != cec_retry_rx_pkg::AGE_EMPTY && age_q[i] > rel_age) begin
          age_q[i] <= age_q[i] - 2'h1;
        end
      end
      // a store in the release cycle lands after renumbering
      if (store_ok) begin
        age_q[free_idx] <= nbuf_used - ((rel_age != cec_retry_rx_pkg::AGE_EMPTY) ? 2'h1 : 2'h0)
                           + cec_retry_rx_pkg::AGE_FIRST;
      end
    end
  end

  // R11: refuse-ack
  // R10: completion event
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_ack_enable  <= 1'b0;
      rx_store       <= 1'b0;
      rx_store_index <= 2'h0;
      rx_event       <= 1'b0;
    end else begin
      rx_ack_enable  <= module_power_on && !rx_refuse_ack_q && addr_hit && free_any;
      rx_store       <= store_ok;
      rx_store_index <= free_idx;
      rx_event       <= store_ok;
    end
  end

  // read mux; R17 places the ages
  always_comb begin
    rdata  = 32'h0;
    mapped = 1'b1;
    unique case (idx)
      cec_retry_rx_pkg::IDX_RETRY:
        rdata[cec_retry_rx_pkg::RETRY_LSB +: 3] = tx_retry_limit_q;
      cec_retry_rx_pkg::IDX_ERRCNT:
        rdata[7:0] = {tx_low_drive_count_q, tx_noack_count_q};
      cec_retry_rx_pkg::IDX_RXCTRL: begin
        rdata[cec_retry_rx_pkg::REFUSE_BIT]    = rx_refuse_ack_q;
        rdata[cec_retry_rx_pkg::MASK_LSB +: 3] = rx_address_enable_mask_q;
      end
      cec_retry_rx_pkg::IDX_LADDR01: rdata[7:0] = {laddr_q[1], laddr_q[0]};
      cec_retry_rx_pkg::IDX_LADDR2:  rdata[3:0] = laddr_q[2];
      cec_retry_rx_pkg::IDX_POWER:   rdata[0] = module_power_on;
      cec_retry_rx_pkg::IDX_TXGO:    rdata[0] = tx_go;
      cec_retry_rx_pkg::IDX_AGE:     rdata[5:0] = {age_q[2], age_q[1], age_q[0]};
      cec_retry_rx_pkg::IDX_BUFMODE: rdata[0] = rx_multi_buffer_enable_q;
      cec_retry_rx_pkg::IDX_TXSTAT:  rdata[2:0] = tx_status_q;
      cec_retry_rx_pkg::IDX_CLEAR, cec_retry_rx_pkg::IDX_RXRELEASE: ;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else if ((avs_read || avs_write) && !waited_q) begin
      avs_readdata <= avs_read ? rdata : 32'h0;
      avs_response <= mapped ? 2'h0 : 2'h3;
    end
  end

  property p_exhaust_sets;
    @(posedge clock) disable iff (rst)
      tx_retry_exhausted_live && !tx_done_ok && !tx_arb_lost
      |=> tx_status_q[cec_retry_rx_pkg::RETRY_EXH_BIT] && !tx_go;
  endproperty
  a_exhaust_sets: assert property (p_exhaust_sets) else $error("exhausted flag not set"); // R1

  property p_exhaust_sticks;
    @(posedge clock) disable iff (rst)
      tx_status_q[cec_retry_rx_pkg::RETRY_EXH_BIT] && !(wr_acc && idx == cec_retry_rx_pkg::IDX_CLEAR)
      |=> tx_status_q[cec_retry_rx_pkg::RETRY_EXH_BIT];
  endproperty
  a_exhaust_sticks: assert property (p_exhaust_sticks) else $error("exhausted flag dropped"); // R2

  property p_counters_clear;
    @(posedge clock) disable iff (rst)
      wr_acc && idx == cec_retry_rx_pkg::IDX_TXGO && avs_writedata[0]
      |=> tx_noack_count_q == 4'h0 && tx_low_drive_count_q == 4'h0 && attempts_q == 3'h0;
  endproperty
  a_counters_clear: assert property (p_counters_clear) else $error("counters not cleared"); // R8

  property p_noack_counts;
    @(posedge clock) disable iff (rst)
      tx_go && tx_noack_event && !wr_acc |=> tx_noack_count_q == $past(tx_noack_count_q) + 4'h1;
  endproperty
  a_noack_counts: assert property (p_noack_counts) else $error("noack count wrong"); // R6

  property p_one_outcome;
    @(posedge clock) disable iff (rst)
      tx_end |=> $countones(tx_status_q & ~$past(tx_status_q)) <= 1;
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("two outcomes flagged"); // R19

  property p_single_buffer;
    @(posedge clock) disable iff (rst)
      !rx_multi_buffer_enable_q && store_ok |-> free_idx == 2'h0;
  endproperty
  a_single_buffer: assert property (p_single_buffer) else $error("extra buffer used"); // R15

  property p_refuse;
    @(posedge clock) disable iff (rst)
      rx_refuse_ack_q |=> !rx_ack_enable && !rx_store;
  endproperty
  a_refuse: assert property (p_refuse) else $error("acknowledged while refusing"); // R11

  property p_store_event;
    @(posedge clock) disable iff (rst)
      store_ok |=> rx_event && age_q[$past(free_idx)] != cec_retry_rx_pkg::AGE_EMPTY;
  endproperty
  a_store_event: assert property (p_store_event) else $error("store without age"); // R10
endmodule

/* File: cec_retry_rx_pkg.sv */
// constants for the transmit retry and receive acceptance block
// assumes an avalon-mm slave with byte-wide register indices
package cec_retry_rx_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  IDX_RETRY         = 8'h12;
  localparam logic [7:0]  IDX_ERRCNT        = 8'h14;
  localparam logic [7:0]  IDX_RXCTRL        = 8'h27;
  localparam logic [7:0]  IDX_LADDR01       = 8'h28;
  localparam logic [7:0]  IDX_LADDR2        = 8'h29;
  localparam logic [7:0]  IDX_POWER         = 8'h2A;
  localparam logic [7:0]  IDX_AGE           = 8'h53;
  localparam logic [7:0]  IDX_BUFMODE       = 8'h77;
  localparam logic [7:0]  IDX_TXSTAT        = 8'h93;
  localparam logic [7:0]  IDX_TXGO          = 8'h11;
  localparam logic [7:0]  IDX_CLEAR         = 8'hA0;
  localparam logic [7:0]  IDX_RXRELEASE     = 8'hA1;
  localparam int          RETRY_LSB         = 4;
  localparam int          REFUSE_BIT        = 1;
  localparam int          MASK_LSB          = 4;
  localparam int          LADDR1_LSB        = 4;
  localparam int          LOWCNT_LSB        = 4;
  localparam int          RETRY_EXH_BIT     = 2;
  localparam int          ARB_BIT           = 1;
  localparam int          SENT_BIT          = 0;
  localparam logic [2:0]  RETRY_RST         = 3'h1;
  localparam logic [3:0]  LADDR_RST         = 4'hF;
  localparam logic [2:0]  MASK_RST          = 3'h0;
  localparam logic [1:0]  AGE_EMPTY         = 2'h0;
  localparam logic [1:0]  AGE_FIRST         = 2'h1;
  localparam logic [1:0]  AGE_THIRD         = 2'h3;
  localparam int          NBUF              = 3;
endpackage

/* File: cec_bus_partner.sv */
// model of the far bus side: bit engine events and received message headers
// assumes the bench calls one task at a time; events are one-cycle pulses
`timescale 1ns/1ps
module cec_bus_partner (
  input  wire logic       clock,
  output logic            tx_noack_event,
  output logic            low_drive_error,
  output logic            tx_done_ok,
  output logic            tx_arb_lost,
  output logic            rx_frame_end,
  output logic      [3:0] rx_dest_addr,
  output logic            rx_is_polling
);
  initial begin
    {tx_noack_event, low_drive_error, tx_done_ok, tx_arb_lost} = 4'h0;
    rx_frame_end  = 1'b0;
    rx_dest_addr  = 4'h0;
    rx_is_polling = 1'b0;
  end

  // kind 0 no-ack, 1 low drive, 2 sent, 3 arbitration lost
  task automatic tx_event(input int kind);
    @(posedge clock);
    {tx_noack_event, low_drive_error, tx_done_ok, tx_arb_lost} <= 4'h8 >> kind;
    @(posedge clock);
    {tx_noack_event, low_drive_error, tx_done_ok, tx_arb_lost} <= 4'h0;
    repeat (3) @(posedge clock);
  endtask

  task automatic frame(input logic [3:0] dest, input logic poll);
    @(posedge clock);
    rx_frame_end  <= 1'b1;
    rx_dest_addr  <= dest;
    rx_is_polling <= poll;
    @(posedge clock);
    rx_frame_end  <= 1'b0;
    // header no longer valid: show its inverse so a stale match cannot hide
    rx_dest_addr  <= ~dest;
    rx_is_polling <= ~poll;
    repeat (3) @(posedge clock);
  endtask
endmodule

/* File: test_cec_retry_rx.sv */
// self-checking bench for the retry and receive acceptance block
// assumes the partner model supplies all bit engine and header traffic
`timescale 1ns/1ps
module test_cec_retry_rx;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        tx_noack_event, low_drive_error, tx_done_ok, tx_arb_lost;
  logic        rx_frame_end, rx_is_polling;
  logic [3:0]  rx_dest_addr;
  logic        tx_go, tx_retransmit, module_power_on, rx_ack_enable;
  logic        rx_store, rx_event;
  logic [1:0]  rx_store_index, sidx, rsp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          compares = 0;
  int          retx = 0;
  int          stores = 0;
  int          evts = 0;
  logic        fe_q = 1'b0;
  logic        ack_seen = 1'b0;

  cec_retry_rx dut_u (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .tx_noack_event(tx_noack_event), .low_drive_error(low_drive_error),
    .tx_done_ok(tx_done_ok), .tx_arb_lost(tx_arb_lost), .rx_frame_end(rx_frame_end),
    .rx_dest_addr(rx_dest_addr), .rx_is_polling(rx_is_polling), .tx_go(tx_go),
    .tx_retransmit(tx_retransmit), .module_power_on(module_power_on),
    .rx_ack_enable(rx_ack_enable), .rx_store(rx_store),
    .rx_store_index(rx_store_index), .rx_event(rx_event));

  cec_bus_partner p (.clock(clock), .tx_noack_event(tx_noack_event),
    .low_drive_error(low_drive_error), .tx_done_ok(tx_done_ok),
    .tx_arb_lost(tx_arb_lost), .rx_frame_end(rx_frame_end),
    .rx_dest_addr(rx_dest_addr), .rx_is_polling(rx_is_polling));

  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (tx_retransmit === 1'b1) retx <= retx + 1;
    if (rx_event === 1'b1) evts <= evts + 1;
    // ack level is registered from the header, so it is taken one edge after the frame end
    fe_q <= rx_frame_end;
    if (fe_q === 1'b1) ack_seen <= rx_ack_enable;
    if (rx_store === 1'b1) begin
      stores <= stores + 1;
      sidx   <= rx_store_index;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // holds the request until waitrequest is sampled low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      fail_count++;
      results();
    end
    rdata = avs_readdata;
    rsp   = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, {24'h0, rdata[7:0]}, {24'h0, e});
  endtask

  task automatic t_reset();
    rd(cec_retry_rx_pkg::IDX_RETRY, 8'h10, "retry_limit");
    rd(cec_retry_rx_pkg::IDX_ERRCNT, 8'h00, "err_counts");
    rd(cec_retry_rx_pkg::IDX_RXCTRL, 8'h00, "rx_ctrl");
    rd(cec_retry_rx_pkg::IDX_LADDR01, 8'hFF, "laddr01");
    rd(cec_retry_rx_pkg::IDX_LADDR2, 8'h0F, "laddr2");
    rd(cec_retry_rx_pkg::IDX_AGE, 8'h00, "ages");
    rd(cec_retry_rx_pkg::IDX_BUFMODE, 8'h00, "bufmode");
    rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h00, "txstat");
    rd(cec_retry_rx_pkg::IDX_POWER, 8'h00, "power_rst");
    rd(cec_retry_rx_pkg::IDX_TXGO, 8'h00, "go_rst");
    rd(8'hFE, 8'h00, "unmapped");
    chk("unmapped_resp", rsp, 2'h3);
  endtask

  // limit 1 is the reset value, limit 3 a programmed one
  task automatic t_retry();
    int lim, k, r0;
    for (lim = 1; lim <= 3; lim += 2) begin
      // limit kept at five or less
      wr(cec_retry_rx_pkg::IDX_RETRY, lim << 4);
      wr(cec_retry_rx_pkg::IDX_TXGO, 32'h1);
      rd(cec_retry_rx_pkg::IDX_ERRCNT, 8'h00, "cnt_at_start");
      r0 = retx;
      for (k = 0; k < lim; k++) p.tx_event(k % 2);
      chk("retransmits", retx - r0, lim);
      rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h00, "not_yet");
      p.tx_event(lim % 2);
      chk("no_extra", retx - r0, lim);
      chk("go_cleared", tx_go, 1'b0);
      rd(cec_retry_rx_pkg::IDX_ERRCNT, lim == 1 ? 8'h11 : 8'h22, "err_counts");
      rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h04, "exhausted");
      wr(cec_retry_rx_pkg::IDX_TXGO, 32'h1);
      rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h04, "sticky");
      wr(cec_retry_rx_pkg::IDX_TXGO, 32'h0);
      wr(cec_retry_rx_pkg::IDX_CLEAR, 32'h4);
      rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h00, "cleared");
    end
  endtask

  task automatic t_outcomes();
    wr(cec_retry_rx_pkg::IDX_TXGO, 32'h1);
    p.tx_event(3);
    rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h02, "arb_only");
    wr(cec_retry_rx_pkg::IDX_CLEAR, 32'h7);
    wr(cec_retry_rx_pkg::IDX_TXGO, 32'h1);
    @(posedge clock);
    chk("go_set", tx_go, 1'b1);
    p.tx_event(2);
    chk("go_done", tx_go, 1'b0);
    rd(cec_retry_rx_pkg::IDX_TXSTAT, 8'h01, "sent_only");
    wr(cec_retry_rx_pkg::IDX_CLEAR, 32'h7);
  endtask

  task automatic t_rx();
    wr(cec_retry_rx_pkg::IDX_RXCTRL, 32'h70);
    wr(cec_retry_rx_pkg::IDX_LADDR01, 32'h53);
    wr(cec_retry_rx_pkg::IDX_LADDR2, 32'h07);
    p.frame(4'h3, 1'b0);
    chk("off_store", stores, 0);
    chk("off_ack", ack_seen, 1'b0);
    wr(cec_retry_rx_pkg::IDX_POWER, 32'h1);
    @(posedge clock);
    chk("power", module_power_on, 1'b1);
    p.frame(4'h3, 1'b1);
    chk("ack_on", ack_seen, 1'b1);
    chk("poll_store", stores, 0);
    p.frame(4'h3, 1'b0);
    chk("store0", stores, 1);
    chk("idx0", sidx, 2'h0);
    chk("event", evts, 1);
    rd(cec_retry_rx_pkg::IDX_AGE, 8'h01, "age_one");
    p.frame(4'h5, 1'b0);
    chk("single_full", stores, 1);
    wr(cec_retry_rx_pkg::IDX_RXCTRL, 32'h12);
    wr(cec_retry_rx_pkg::IDX_RXRELEASE, 32'h0);
    p.frame(4'h3, 1'b0);
    chk("ack_off", ack_seen, 1'b0);
    chk("refused", stores, 1);
    wr(cec_retry_rx_pkg::IDX_RXCTRL, 32'h10);
    p.frame(4'h5, 1'b0);
    chk("masked", stores, 1);
    wr(cec_retry_rx_pkg::IDX_RXCTRL, 32'h70);
    wr(cec_retry_rx_pkg::IDX_BUFMODE, 32'h1);
    p.frame(4'h3, 1'b0);
    p.frame(4'h5, 1'b0);
    p.frame(4'h7, 1'b0);
    chk("three", stores, 4);
    chk("idx2", sidx, 2'h2);
    rd(cec_retry_rx_pkg::IDX_AGE, 8'h39, "ages_full");
    p.frame(4'h3, 1'b0);
    chk("all_full", stores, 4);
    chk("full_nack", ack_seen, 1'b0);
    wr(cec_retry_rx_pkg::IDX_RXRELEASE, 32'h0);
    rd(cec_retry_rx_pkg::IDX_AGE, 8'h24, "renumber");
    p.frame(4'h7, 1'b0);
    chk("reuse0", sidx, 2'h0);
    rd(cec_retry_rx_pkg::IDX_AGE, 8'h27, "age_new");
  endtask

  // reset in mid-run, with frames buffered, must bring back every reset value
  task automatic t_midreset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_retry();
    t_outcomes();
    t_rx();
    t_midreset();
    results();
  end
endmodule
